// ### acseq_top.sv
/*
  Conversion sequencer for a main and an auxiliary converter channel.
  Opcodes arrive on a serial link clocked by sclk_in; start pin and opcodes both
  steer the main channel. Configuration bits are plain inputs from the same clk_in domain.
*/
`timescale 1ns/1ps
`default_nettype none
module acseq_top
  import acseq_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       din_in,
  input  wire logic       start_pin_in,
  input  wire logic [7:0] first_mode_register_in,
  input  wire logic       chop_en_in,
  input  wire logic       idac_rot_en_in,
  input  wire logic [2:0] filter_sel_in,
  input  wire logic [3:0] rate_sel_in,
  input  wire logic [3:0] delay_sel_in,
  input  wire logic [1:0] aux_rate_sel_in,
  input  wire logic       mux_write_in,
  output logic            result_available_n_out,
  output logic            main_active_out,
  output logic            aux_result_available_n_out,
  output logic            aux_active_out,
  output logic [2:0]      settle_periods_out,
  output logic            cmd_conflict_out
);

  typedef struct packed {
    logic [2:0] cnt;
    logic [5:0] sh;
    logic [3:0] cmd;
  } acseq_link_s;

  typedef struct packed {
    logic         pin_s1;
    logic         pin_s2;
    logic         pin_d;
    logic [3:0]   cmd_s1;
    logic [3:0]   cmd_s2;
    logic [3:0]   cmd_d;
    acseq_state_e mst;
    logic [31:0]  mtimer;
    logic         pulse;
    logic         halt;
    logic         halt_next;
    logic         result_available_n;
    logic [4:0]   result_available_n_cnt;
    acseq_state_e ast;
    logic [31:0]  atimer;
    logic         adrdy;
    logic [4:0]   adrdy_cnt;
    logic [2:0]   settle;
    logic         conflict;
    logic         main_act;
    logic         aux_act;
  } acseq_core_s;

  acseq_link_s l;
  acseq_link_s next_l;
  acseq_core_s q;
  acseq_core_s next_q;

  logic [3:0]  cmd_ev;
  logic        start_c;
  logic        stop_c;
  logic        pulse_sel;
  logic        restart;
  logic        stop_early;
  logic        stop_late;
  logic [25:0] delay_ticks;
  logic [25:0] base_ticks;
  logic [31:0] first_cyc;
  logic [31:0] period_cyc;
  logic [51:0] aux_ticks;
  logic [31:0] aux_first_cyc;
  logic [31:0] aux_period_cyc;

  // Serial side: frame ends with cs_n high, which also clears the command levels.
  // Command levels stay high until the next falling edge with cs_n high or the next byte's first edge, long enough for the sync.
  always_comb begin
    next_l = l;
    if (cs_n_in) begin
      next_l = '0;
    end else begin
      next_l.sh  = {l.sh[4:0], din_in};                            // RULE26
      next_l.cnt = l.cnt + 3'h1;
      if (l.cnt == 3'h0) begin
        next_l.cmd = 4'h0;
      end
      if (l.cnt == OPCODE_EDGE) begin                              // RULE3
        case ({l.sh, din_in})
          OP_MAIN_START[7:1]: next_l.cmd = 4'h1;                   // RULE4
          OP_MAIN_STOP[7:1]:  next_l.cmd = 4'h2;                   // RULE5
          OP_AUX_START[7:1]:  next_l.cmd = 4'h4;                   // RULE6
          OP_AUX_STOP[7:1]:   next_l.cmd = 4'h8;                   // RULE6
          default:            next_l.cmd = 4'h0;
        endcase
      end
    end
  end

  always_ff @(negedge sclk_in) begin
    l <= next_l;
  end

  // Timing from the rate table, chop/rotation multipliers and programmed delay
  always_comb begin
    delay_ticks = (delay_sel_in == 4'h0) ? 26'd0 : (DELAY_STEP_TICKS << (delay_sel_in - 4'h1));
    base_ticks  = acseq_lat(filter_sel_in, rate_sel_in) + delay_ticks;          // RULE22
    if (chop_en_in && idac_rot_en_in) begin
      first_cyc = 32'({base_ticks, 2'b00} * TICK_CYC);                        // RULE23
    end else if (chop_en_in || idac_rot_en_in) begin
      first_cyc = 32'({base_ticks, 1'b0} * TICK_CYC);                         // RULE23
    end else begin
      first_cyc = 32'(base_ticks * TICK_CYC);
    end
    if (chop_en_in || idac_rot_en_in) begin
      period_cyc = 32'(base_ticks * TICK_CYC);                                // RULE24
    end else begin
      period_cyc = 32'(acseq_period(rate_sel_in) * TICK_CYC);                 // RULE21
    end
    aux_ticks      = acseq_aux(aux_rate_sel_in);
    aux_first_cyc  = 32'(aux_ticks[51:26] * TICK_CYC);                        // RULE25
    aux_period_cyc = 32'(aux_ticks[25:0] * TICK_CYC);
  end

  always_comb begin
    next_q = q;
    next_q.pin_s1 = start_pin_in;
    next_q.pin_s2 = q.pin_s1;
    next_q.pin_d  = q.pin_s2;
    next_q.cmd_s1 = l.cmd;
    next_q.cmd_s2 = q.cmd_s1;
    next_q.cmd_d  = q.cmd_s2;
    cmd_ev  = q.cmd_s2 & ~q.cmd_d;
    // Pin edges assume the host keeps the pin's high and low widths
    start_c = (q.pin_s2 & ~q.pin_d) | cmd_ev[0];                   // RULE28 RULE7 RULE8
    stop_c  = (~q.pin_s2 & q.pin_d) | cmd_ev[1];                   // RULE12
    pulse_sel = first_mode_register_in[RUN_SELECT_BIT] & ~chop_en_in;  // RULE2 RULE17
    restart = start_c | (mux_write_in & (q.mst != ST_IDLE));       // RULE20
    stop_early = stop_c & ~q.pulse & (q.mst != ST_IDLE) & (q.mtimer >= STOP_SETUP_CYC);
    stop_late  = stop_c & ~q.pulse & (q.mst != ST_IDLE) & (q.mtimer < STOP_SETUP_CYC);
    next_q.settle = (filter_sel_in == FILT_FIR) ? 3'h1 :
                    (filter_sel_in > FILT_SINC5) ? 3'h1 : filter_sel_in + 3'h1;  // RULE19 RULE27
    if ((cmd_ev[0] | cmd_ev[1]) & q.pin_s2) begin
      next_q.conflict = 1'b1;                                      // RULE1
    end

    // Main channel
    if (q.mtimer != 32'h0) begin
      next_q.mtimer = q.mtimer - 32'h1;
    end
    if (q.result_available_n_cnt != 5'h0) begin
      next_q.result_available_n_cnt = q.result_available_n_cnt - 5'h1;
      if (q.result_available_n_cnt == 5'h1) begin
        next_q.result_available_n = 1'b1;
      end
    end
    if (restart) begin
      next_q.mst       = ST_FIRST;
      next_q.mtimer    = first_cyc;
      next_q.pulse     = pulse_sel;
      next_q.halt      = 1'b0;
      next_q.halt_next = 1'b0;
      next_q.result_available_n      = 1'b1;                                     // RULE13 RULE9
      next_q.result_available_n_cnt  = 5'h0;
    end else if (q.mst != ST_IDLE) begin
      if (stop_early) begin
        next_q.halt = 1'b1;                                        // RULE10
      end
      if (stop_late) begin
        next_q.halt_next = 1'b1;                                   // RULE11
      end
      // Stops in pulse mode never reach halt flags
      if (q.mtimer == 32'h1) begin
        next_q.result_available_n     = 1'b0;                                    // RULE14
        next_q.result_available_n_cnt = RESULT_AVAILABLE_N_LOW_CYC;
        if (q.pulse || q.halt) begin
          next_q.mst    = ST_IDLE;                                 // RULE15 RULE16
          next_q.mtimer = 32'h0;
          next_q.halt   = 1'b0;
        end else begin
          next_q.mst       = ST_RUN;                               // RULE12 RULE21
          next_q.mtimer    = period_cyc;
          next_q.halt      = q.halt_next | stop_late;              // RULE11
          next_q.halt_next = 1'b0;
        end
      end
    end

    // Auxiliary channel, independent of the main one
    if (q.atimer != 32'h0) begin
      next_q.atimer = q.atimer - 32'h1;
    end
    if (q.adrdy_cnt != 5'h0) begin
      next_q.adrdy_cnt = q.adrdy_cnt - 5'h1;
      if (q.adrdy_cnt == 5'h1) begin
        next_q.adrdy = 1'b1;
      end
    end
    if (cmd_ev[2]) begin
      next_q.ast       = ST_FIRST;                                 // RULE18
      next_q.atimer    = aux_first_cyc;                            // RULE25
      next_q.adrdy     = 1'b1;
      next_q.adrdy_cnt = 5'h0;
    end else if (cmd_ev[3]) begin
      next_q.ast    = ST_IDLE;                                     // RULE18
      next_q.atimer = 32'h0;
    end else if (q.ast != ST_IDLE && q.atimer == 32'h1) begin
      next_q.ast       = ST_RUN;
      next_q.atimer    = aux_period_cyc;
      next_q.adrdy     = 1'b0;
      next_q.adrdy_cnt = RESULT_AVAILABLE_N_LOW_CYC;
    end
    // Activity flags are registered so the outputs leave flip-flops directly
    next_q.main_act = next_q.mst != ST_IDLE;
    next_q.aux_act  = next_q.ast != ST_IDLE;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q       <= '0;
      q.result_available_n  <= 1'b1;
      q.adrdy <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign result_available_n_out     = q.result_available_n;
  assign main_active_out            = q.main_act;
  assign aux_result_available_n_out = q.adrdy;
  assign aux_active_out             = q.aux_act;
  assign settle_periods_out         = q.settle;
  assign cmd_conflict_out           = q.conflict;

  // Checks on the core domain; the opcode decode check runs on the serial clock
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_pulse_result_available_n_high: assert property (start_c && pulse_sel |-> ##[1:2] q.result_available_n) // RULE9
    else $error("data-ready not high within two clocks of pulse start");
  a_result_available_n_fall_cause: assert property ($fell(q.result_available_n) |-> $past(q.mtimer) == 32'h1) // RULE14
    else $error("data-ready fell without a finished conversion");
  a_restart_result_available_n: assert property (restart |=> q.mst == ST_FIRST && q.result_available_n && q.mtimer == $past(first_cyc)) // RULE13
    else $error("restart did not reload first latency with data-ready high");
  a_pulse_one_shot: assert property (q.pulse && !restart && q.mst != ST_IDLE && q.mtimer == 32'h1 |=> q.mst == ST_IDLE && !q.result_available_n) // RULE15
    else $error("pulse mode did not halt after one result");
  a_pulse_stop_ign: assert property (stop_c && q.pulse && q.mst != ST_IDLE && q.mtimer > 32'h1 && !restart |=> q.mst != ST_IDLE && !q.halt) // RULE16
    else $error("stop acted during a pulse conversion");
  a_early_stop_halt: assert property (stop_early && !restart && q.mtimer > 32'h1 |=> q.halt ##0 (q.mst != ST_IDLE)) // RULE10
    else $error("early stop not recorded");
  a_late_stop_runs: assert property (stop_late && !restart && !q.halt && q.mtimer == 32'h1 |=> q.mst == ST_RUN && q.halt) // RULE11
    else $error("late stop did not allow the following conversion");
  a_mux_restart: assert property (mux_write_in && q.mst != ST_IDLE |=> q.mst == ST_FIRST && q.result_available_n) // RULE20
    else $error("multiplexer write did not restart the conversion");
  a_aux_start_load: assert property (cmd_ev[2] |=> q.ast == ST_FIRST && q.atimer == $past(aux_first_cyc)) // RULE25
    else $error("auxiliary start did not load its latency");
  a_aux_stop_idle: assert property (cmd_ev[3] && !cmd_ev[2] |=> q.ast == ST_IDLE) // RULE18
    else $error("auxiliary stop did not halt the channel");
  a_chop_no_pulse: assert property (restart && chop_en_in |=> !q.pulse) // RULE17
    else $error("pulse mode combined with chop");
  a_run_reload: assert property (q.mst != ST_IDLE && q.mtimer == 32'h1 && !q.pulse && !q.halt && !restart |=> q.mtimer == $past(period_cyc)) // RULE21
    else $error("continuous period not reloaded");

  a_opcode_decode: assert property (@(negedge sclk_in) disable iff (cs_n_in)
      l.cnt == OPCODE_EDGE && {l.sh, din_in} == OP_MAIN_START[7:1] |=> l.cmd == 4'h1) // RULE3
    else $error("main start opcode not decoded on seventh edge");

endmodule
`default_nettype wire

// ### acseq_pkg.sv
/*
  Constants, state encodings and rate lookups for the conversion sequencer.
  Assumes the master clock is clk_in at 100 MHz, so one master clock period equals one cycle.
*/
// Contract
// [RULE1] Host keeps the start pin low while it steers the main channel by opcodes.
// [RULE2] Run-select bit 6 of the first mode register picks continuous or pulse.
// [RULE3] Start and stop opcodes act on the seventh falling serial clock edge.
// [RULE4] Opcode 08h or 09h starts the main channel.
// [RULE5] Opcode 0Ah or 0Bh stops the main channel.
// [RULE6] Opcodes 0Ch/0Dh start and 0Eh/0Fh stop the auxiliary channel.
// [RULE7] Host holds the start pin high at least 4 master clocks.
// [RULE8] Host holds the start pin low at least 4 master clocks before restarting.
// [RULE9] Pulse mode raises data-ready within 2 master clocks of a start.
// [RULE10] A stop 16 or more clocks before result ends conversions after the current one.
// [RULE11] A stop under 16 clocks before result lets the following conversion finish.
// [RULE12] Continuous mode keeps converting until pin low or stop opcode.
// [RULE13] Restarting a running conversion drives data-ready high.
// [RULE14] Data-ready falls as soon as a new result exists.
// [RULE15] Pulse mode makes exactly one conversion per start, then halts.
// [RULE16] Pulse mode ignores a stop opcode during a conversion.
// [RULE17] Chop forces continuous behaviour; pulse mode is not combined with chop.
// [RULE18] Auxiliary channel runs alone, opcode driven, continuous, restarts on stop-start.
// [RULE19] FIR and sinc1 settle in one cycle; sinc2 to sinc5 need more.
// [RULE20] A multiplexer write during conversions restarts the conversion at once.
// [RULE21] After the first result, continuous results come at the nominal data period.
// [RULE22] First main latency follows the rate and filter table with zero delay.
// [RULE23] Chop or rotation doubles first latency plus delay; both quadruple it.
// [RULE24] With chop or rotation the period is base latency plus delay.
// [RULE25] Auxiliary first result after 121, 31.2, 8.71 or 4.97 ms.
// [RULE26] Serial input bits are sampled on the falling serial clock edge.
// [RULE27] Settling after a step takes sinc-order periods, one for FIR.
// [RULE28] Pin rising edge or start opcode form one start condition for one machine.
package acseq_pkg;
  localparam int CLK_NS          = 10;
  localparam int TICK_NS         = 100;
  localparam int TICK_CYC_DEF    = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int START_HIGH_MIN  = 4;
  localparam int START_LOW_MIN   = 4;
  localparam int PULSE_RESULT_AVAILABLE_N_MAX  = 2;
  localparam logic [31:0] STOP_SETUP_CYC = 32'h10;
  localparam logic [4:0]  RESULT_AVAILABLE_N_LOW_CYC   = 5'h10;
  localparam int RUN_SELECT_BIT  = 6;
  localparam logic [7:0] OP_MAIN_START = 8'h08;
  localparam logic [7:0] OP_MAIN_STOP  = 8'h0a;
  localparam logic [7:0] OP_AUX_START  = 8'h0c;
  localparam logic [7:0] OP_AUX_STOP   = 8'h0e;
  localparam logic [2:0] OPCODE_EDGE   = 3'h6;
  localparam logic [25:0] DELAY_STEP_TICKS = 26'd87;
  localparam logic [2:0] FILT_SINC1 = 3'h0;
  localparam logic [2:0] FILT_SINC5 = 3'h4;
  localparam logic [2:0] FILT_FIR   = 3'h5;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FIRST = 2'b01,
    ST_RUN   = 2'b10
  } acseq_state_e;

  // Latency in 0.1 us ticks; blank table cells fall back to the populated column
  function automatic logic [25:0] acseq_lat(input logic [2:0] f, input logic [3:0] r);
    logic [23:0] c1, c2, c3, c4, cf;
    cf = 24'd0;
    case (r)
      4'h0: {c1, c2, c3, c4, cf} = {24'd4004000, 24'd8004000, 24'd12000000, 24'd16000000, 24'd4022000};
      4'h1: {c1, c2, c3, c4, cf} = {24'd2004000, 24'd4004000, 24'd6004000, 24'd8004000, 24'd2022000};
      4'h2: {c1, c2, c3, c4, cf} = {24'd1004000, 24'd2004000, 24'd3004000, 24'd4004000, 24'd1022000};
      4'h3: {c1, c2, c3, c4} = {24'd603500, 24'd1204000, 24'd1804000, 24'd2404000};
      4'h4: {c1, c2, c3, c4, cf} = {24'd503500, 24'd1004000, 24'd1504000, 24'd2004000, 24'd522200};
      4'h5: {c1, c2, c3, c4} = {24'd203500, 24'd404200, 24'd604200, 24'd804200};
      4'h6: {c1, c2, c3, c4} = {24'd170200, 24'd337600, 24'd504200, 24'd670900};
      4'h7: {c1, c2, c3, c4} = {24'd103500, 24'd204200, 24'd304200, 24'd404200};
      4'h8: {c1, c2, c3, c4} = {24'd28550, 24'd54240, 24'd79240, 24'd104200};
      4'h9: {c1, c2, c3, c4} = {24'd11880, 24'd20910, 24'd29240, 24'd37580};
      4'ha: {c1, c2, c3, c4} = {24'd7710, 24'd12580, 24'd16740, 24'd20910};
      4'hb: {c1, c2, c3, c4} = {24'd5630, 24'd8409, 24'd10490, 24'd12580};
      4'hc: {c1, c2, c3, c4} = {24'd4940, 24'd7020, 24'd8410, 24'd9800};
      4'hd: {c1, c2, c3, c4} = {4{24'd4240}};
      4'he: {c1, c2, c3, c4} = {4{24'd3370}};
      default: {c1, c2, c3, c4} = {4{24'd2070}};
    endcase
    case (f)
      3'h1: return {2'h0, c2};
      3'h2: return {2'h0, c3};
      3'h3: return {2'h0, c4};
      FILT_SINC5: return {2'h0, (r > 4'hc) ? c4 : c1};
      FILT_FIR: return {2'h0, (cf != 24'd0) ? cf : c1};
      default: return {2'h0, c1};
    endcase
  endfunction

  // Nominal data period in 0.1 us ticks
  function automatic logic [25:0] acseq_period(input logic [3:0] r);
    case (r)
      4'h0: return 26'd4000000;
      4'h1: return 26'd2000000;
      4'h2: return 26'd1000000;
      4'h3: return 26'd602410;
      4'h4: return 26'd500000;
      4'h5: return 26'd200000;
      4'h6: return 26'd166667;
      4'h7: return 26'd100000;
      4'h8: return 26'd25000;
      4'h9: return 26'd8333;
      4'ha: return 26'd4167;
      4'hb: return 26'd2083;
      4'hc: return 26'd1389;
      4'hd: return 26'd694;
      4'he: return 26'd521;
      default: return 26'd260;
    endcase
  endfunction

  // Auxiliary first latency and period, slowest to fastest
  function automatic logic [51:0] acseq_aux(input logic [1:0] r);
    case (r)
      2'h0: return {26'd1210000, 26'd1000000};
      2'h1: return {26'd312000, 26'd100000};
      2'h2: return {26'd87100, 26'd25000};
      default: return {26'd49700, 26'd12500};
    endcase
  endfunction
endpackage

// ### acseq_host_link.sv
/*
  Host-side serial link model: frames one opcode byte per call of send.
  Assumes the sequencer samples din on falling sclk edges while cs_n is low.
*/
`timescale 1ns/1ps
`default_nettype none
module acseq_host_link (
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
    // One edge with cs_n high clears the link before the core leaves reset
    #40 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  end

  // Clock stands low outside frames; 80 ns period, odd phase to the master clock
  task automatic send(input logic [7:0] op);
    #7.3;
    // One edge with cs_n high clears the link, since cs_n is only seen on sclk
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
    #40 cs_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sclk_out = 1'b1;
      #5 din_out = op[i];
      #35 sclk_out = 1'b0;
      #40;
    end
    cs_n_out = 1'b1;
    // Released line shows the inverse, so a stale bit is never mistaken for data
    din_out = ~din_out;
    // Clearing edge drops the command level, so a later reset cannot replay it
    #40 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### adc_conversion_sequencer_test.sv
/*
  Self-checking bench for the conversion sequencer: start pin, opcodes, mux writes.
  Assumes TICK_CYC = 1, so latencies count in 0.1 us ticks of one cycle each.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
  import acseq_pkg::*;
  localparam int N1 = 2070;
  localparam int PER = 260;
  localparam int AL = 49700;
  localparam int LIMIT = 100000;
  logic       clk_in, rst_in, pin, mwr, chop, rot;
  logic [7:0] mode;
  logic [2:0] filt;
  logic [3:0] rate, dly;
  logic [1:0] arate;
  wire logic  sclk, cs_n, din, result_available_n, act, adrdy, aact, confl;
  wire logic [2:0] settle;
  int         miscompares = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         n, lat, per;
  bit         got;

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  acseq_top #(.TICK_CYC(1)) DUT (.clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .start_pin_in(pin), .first_mode_register_in(mode),
    .chop_en_in(chop), .idac_rot_en_in(rot), .filter_sel_in(filt), .rate_sel_in(rate),
    .delay_sel_in(dly), .aux_rate_sel_in(arate), .mux_write_in(mwr),
    .result_available_n_out(result_available_n), .main_active_out(act),
    .aux_result_available_n_out(adrdy), .aux_active_out(aact),
    .settle_periods_out(settle), .cmd_conflict_out(confl));
  acseq_host_link HOST (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));

  task automatic end_sim();
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      $display("unexpected at %0t: run too long", $time);
      end_sim();
    end
  end

  task automatic check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  // Counts edges up to a falling edge of the chosen data-ready output
  task automatic wait_rdy(input bit aux, input int lim, output int cnt, output bit seen);
    logic prev;
    logic now;
    prev = aux ? adrdy : result_available_n;
    cnt = 0;
    seen = 0;
    while (!seen && cnt < lim) begin
      @(posedge clk_in);
      now = aux ? adrdy : result_available_n;
      cnt++;
      seen = (prev === 1'b1) && (now === 1'b0);
      prev = now;
    end
  endtask

  // Pin stays low unless a scenario drives it; widths held at 4 cycles or more
  task automatic set_pin(input logic v, input int hold);
    @(posedge clk_in);
    pin <= v;
    cycles(hold);
  endtask

  task automatic setup(input logic [7:0] m, input logic c, input logic r, input logic [3:0] d);
    @(posedge clk_in);
    rst_in <= 1'b1;
    pin <= 1'b0;
    mode <= m;
    chop <= c;
    rot <= r;
    dly <= d;
    cycles(20);
    rst_in <= 1'b0;
    cycles(2);
  endtask

  initial begin
    rst_in = 1'b1;
    pin = 1'b0;
    mwr = 1'b0;
    chop = 1'b0;
    rot = 1'b0;
    mode = 8'h40;
    filt = 3'h0;
    rate = 4'hf;
    dly = 4'h0;
    arate = 2'h3;
    setup(8'h40, 1'b0, 1'b0, 4'h0);
    check(result_available_n === 1'b1 && act === 1'b0 && confl === 1'b0, "reset outputs");
    for (int f = 0; f < 8; f++) begin
      @(posedge clk_in);
      filt <= 3'(f);
      cycles(3);
      check(settle === ((f >= 5) ? 3'h1 : 3'(f + 1)), "settle periods");
    end
    @(posedge clk_in);
    filt <= 3'h0;
    // Pulse mode: one result per start, restart during the low pulse
    set_pin(1'b1, 4);
    set_pin(1'b0, 0);
    wait_rdy(0, N1 + 20, n, got);
    // Counted from five cycles after the pin rose; the sync adds two or three
    check(got && n >= N1 - 4 && n <= N1 + 2, "pulse first latency");
    set_pin(1'b1, 4);
    check(result_available_n === 1'b1, "restart raises ready");
    set_pin(1'b0, 0);
    wait_rdy(0, N1 + 20, n, got);
    check(got, "pulse result");
    wait_rdy(0, 3 * PER, n, got);
    check(!got && act === 1'b0, "pulse halts");
    // Continuous by opcodes, both opcode variants
    for (int b = 0; b < 2; b++) begin
      setup(8'h00, 1'b0, 1'b0, 4'h0);
      HOST.send(OP_MAIN_START | 8'(b));
      cycles(6);
      check(act === 1'b1 && result_available_n === 1'b1, "opcode start");
      wait_rdy(0, N1 + 20, n, got);
      check(got, "first result");
      wait_rdy(0, PER + 4, n, got);
      check(got && n == PER, "data period");
      HOST.send(OP_MAIN_STOP | 8'(b));
      wait_rdy(0, PER + 4, n, got);
      check(got, "current result");
      wait_rdy(0, 2 * PER, n, got);
      check(!got && act === 1'b0 && confl === 1'b0, "opcode stop");
    end
    // Pin stop early and late in a period
    for (int k = 0; k < 2; k++) begin
      setup(8'h00, 1'b0, 1'b0, 4'h0);
      set_pin(1'b1, 4);
      wait_rdy(0, N1 + 20, n, got);
      cycles(k ? PER - 12 : 10);
      set_pin(1'b0, 0);
      wait_rdy(0, PER + 4, n, got);
      check(got, "finishing result");
      wait_rdy(0, PER + 4, n, got);
      check(got == bit'(k), "following result");
      wait_rdy(0, PER + 4, n, got);
      check(!got, "stopped");
    end
    setup(8'h40, 1'b0, 1'b0, 4'h0);
    HOST.send(OP_MAIN_START);
    HOST.send(OP_MAIN_STOP);
    wait_rdy(0, N1 + 20, n, got);
    check(got, "pulse stop ignored");
    // Multiplexer write during the low pulse restarts the conversion
    setup(8'h00, 1'b0, 1'b0, 4'h0);
    set_pin(1'b1, 4);
    wait_rdy(0, N1 + 20, n, got);
    mwr <= 1'b1;
    @(posedge clk_in);
    mwr <= 1'b0;
    cycles(3);
    check(result_available_n === 1'b1, "mux restart ready");
    wait_rdy(0, N1 + 20, n, got);
    check(got && n >= N1 - 8 && n <= N1 + 2, "mux restart latency");
    HOST.send(OP_MAIN_START);
    cycles(6);
    check(confl === 1'b1, "opcode with pin high not flagged");
    // Chop with pulse bit set still runs continuously
    for (int k = 1; k < 3; k++) begin
      lat = (k == 1) ? 2 * (N1 + 87) : 4 * N1;
      per = (k == 1) ? N1 + 87 : N1;
      setup(8'h40, 1'b1, k == 2, (k == 1) ? 4'h1 : 4'h0);
      set_pin(1'b1, 0);
      wait_rdy(0, lat + 20, n, got);
      check(got && n >= lat && n <= lat + 6, "chop latency");
      wait_rdy(0, per + 4, n, got);
      check(got && n == per, "chop period");
    end
    // Auxiliary channel runs alone
    setup(8'h00, 1'b0, 1'b0, 4'h0);
    HOST.send(OP_AUX_START | 8'h01);
    cycles(6);
    check(aact === 1'b1 && act === 1'b0, "aux start alone");
    wait_rdy(1, AL + 20, n, got);
    check(got && n >= AL - 40 && n <= AL + 4, "aux latency");
    HOST.send(OP_AUX_STOP);
    cycles(6);
    check(aact === 1'b0 && result_available_n === 1'b1, "aux stop");
    HOST.send(OP_AUX_START);
    cycles(6);
    check(aact === 1'b1, "aux restart");
    HOST.send(OP_AUX_STOP | 8'h01);
    cycles(6);
    check(aact === 1'b0, "aux stop odd");
    end_sim();
  end
endmodule
`default_nettype wire
